// [rtl/iclkg_pkg.sv]
package iclkg_pkg;

	// System clock and loop target
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned NOM_FREQ_HZ = 307_200;
	localparam int unsigned NOM_PERIOD_CYC = CLK_HZ / NOM_FREQ_HZ;

	// Control word layout and limits
	localparam int unsigned STAGE_W = 8;
	localparam int unsigned DIV_W = 4;
	localparam int unsigned WORD_W = DIV_W + STAGE_W;
	localparam logic [DIV_W-1:0] DIV_SLOWEST = 4'h9;
	localparam logic [WORD_W-1:0] WORD_MIN = 12'h000;
	localparam logic [WORD_W-1:0] WORD_MAX = 12'h9ff;
	localparam logic [WORD_W-1:0] WORD_RESET = 12'h510;

	// Ring oscillator model: half period = OSC_HALF_MIN + (word >> OSC_SHIFT), with the divider nibble capped at DIV_SLOWEST
	localparam int unsigned OSC_HALF_MIN = 1;
	localparam int unsigned OSC_SHIFT = 3;

	// Error band thresholds, in percent of nominal
	localparam int unsigned PCT_SCALE = 100;
	localparam int unsigned PCT_85 = 85;
	localparam int unsigned PCT_95 = 95;
	localparam int unsigned PCT_105 = 105;
	localparam int unsigned PCT_115 = 115;

	// Correction step sizes
	localparam logic [WORD_W-1:0] STEP_FINE = 12'h001;
	localparam logic [WORD_W-1:0] STEP_MID = 12'h008;
	localparam logic [WORD_W-1:0] STEP_COARSE = 12'h020;

	// Counter widths
	localparam int unsigned HALF_W = 16;
	localparam int unsigned PER_W = 16;
	localparam int unsigned PROD_W = 24;
	localparam int unsigned MULT_W = 7;

	// Comparator result: base clock frequency relative to nominal
	typedef enum logic [2:0] {
		BAND_VSLOW = 3'h0,
		BAND_SLOW = 3'h1,
		BAND_LSLOW = 3'h3,
		BAND_LFAST = 3'h2,
		BAND_FAST = 3'h6,
		BAND_VFAST = 3'h7
	} iclkg_band_type;

	// Derived clocks as seen downstream
	typedef struct packed {
		logic fast_internal_clock;
		logic base_clock;
		logic external_clock;
		logic osc_output_clock;
		logic gen_output_clock;
		logic bus_clock;
	} iclkg_clocks_type;

	// Enable chain
	typedef struct packed {
		logic clock_gen_halt;
		logic int_osc_enable;
		logic ext_path_enable;
	} iclkg_enables_type;

	// Whole module state
	typedef struct packed {
		iclkg_enables_type en;
		iclkg_clocks_type clk;
		logic [WORD_W-1:0] word;
		logic [HALF_W-1:0] half_cnt;
		logic [MULT_W-1:0] div_cnt;
		logic [PER_W-1:0] per_cnt;
		logic seen_edge;
		iclkg_band_type band;
		logic band_valid;
		logic filter_stable_flag;
	} iclkg_state_type;

endpackage

// [rtl/iclkg_core.sv]
`timescale 1ns/1ns
module iclkg_core #(
	parameter int unsigned MULT_WIDTH = iclkg_pkg::MULT_W,
	parameter int unsigned NOM_PERIOD = iclkg_pkg::NOM_PERIOD_CYC,
	parameter logic [iclkg_pkg::WORD_W-1:0] WORD_INIT = iclkg_pkg::WORD_RESET
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Mode and control bits
	input wire logic stop_mode,
	input wire logic int_osc_on_bit,
	input wire logic ext_path_on_bit,
	input wire logic [MULT_WIDTH-1:0] multiplier_register,
	// External clock pin
	input wire logic ext_clock_in,
	// Enables
	output iclkg_pkg::iclkg_enables_type enables,
	// Generated clocks
	output iclkg_pkg::iclkg_clocks_type clocks,
	// Loop state
	output logic [iclkg_pkg::DIV_W-1:0] osc_divider_ctl,
	output logic [iclkg_pkg::STAGE_W-1:0] osc_stage_ctl,
	output iclkg_pkg::iclkg_band_type error_band,
	output logic error_band_valid,
	output logic filter_stable_flag
);

	iclkg_pkg::iclkg_state_type state;
	iclkg_pkg::iclkg_state_type next_state;

	// Period scaled by a percentage, wide enough for any count
	function automatic logic [iclkg_pkg::PROD_W-1:0] scaled(
		input logic [iclkg_pkg::PER_W-1:0] value,
		input int unsigned pct
	);
		logic [iclkg_pkg::PROD_W-1:0] wide;
		wide = iclkg_pkg::PROD_W'(value) * iclkg_pkg::PROD_W'(pct);
		return wide;
	endfunction

	// Divider nibble as the oscillator sees it
	function automatic logic [iclkg_pkg::WORD_W-1:0] effective_word(
		input logic [iclkg_pkg::WORD_W-1:0] word
	);
		logic [iclkg_pkg::DIV_W-1:0] div;
		div = word[iclkg_pkg::WORD_W-1:iclkg_pkg::STAGE_W];
		if (div > iclkg_pkg::DIV_SLOWEST) begin
			div = iclkg_pkg::DIV_SLOWEST;
		end
		return {div, word[iclkg_pkg::STAGE_W-1:0]};
	endfunction

	logic [iclkg_pkg::PROD_W-1:0] nom_scaled;
	logic [iclkg_pkg::HALF_W-1:0] half_len;
	logic [iclkg_pkg::WORD_W-1:0] eff_word;
	logic bypass;
	logic fast_rise;
	logic base_rise;
	logic gen_rise;
	logic [iclkg_pkg::PER_W-1:0] period;
	iclkg_pkg::iclkg_band_type band;
	logic [iclkg_pkg::WORD_W-1:0] step;
	logic step_up;

	// Next-state logic for the whole block
	always_comb begin
		next_state = state;
		nom_scaled = scaled(iclkg_pkg::PER_W'(NOM_PERIOD), iclkg_pkg::PCT_SCALE);
		eff_word = effective_word(state.word);
		half_len = iclkg_pkg::HALF_W'(iclkg_pkg::OSC_HALF_MIN)
			+ iclkg_pkg::HALF_W'(eff_word >> iclkg_pkg::OSC_SHIFT);
		bypass = (multiplier_register <= MULT_WIDTH'(1));
		fast_rise = 1'b0;
		base_rise = 1'b0;
		gen_rise = 1'b0;
		period = state.per_cnt;
		band = state.band;
		step = iclkg_pkg::STEP_FINE;
		step_up = 1'b0;

		// Enable chain; halt uses the live mode so enables drop in the same edge
		next_state.en.clock_gen_halt = stop_mode;
		next_state.en.int_osc_enable = int_osc_on_bit && !stop_mode;
		next_state.en.ext_path_enable = ext_path_on_bit && !stop_mode;

		// External path: pin is already synchronous, gated by enable
		next_state.clk.external_clock = ext_clock_in && next_state.en.ext_path_enable;

		if (!next_state.en.int_osc_enable) begin
			// Generator off: everything internal low, counters parked
			next_state.clk.fast_internal_clock = 1'b0;
			next_state.clk.base_clock = 1'b0;
			next_state.clk.osc_output_clock = 1'b0;
			next_state.clk.gen_output_clock = 1'b0;
			next_state.clk.bus_clock = 1'b0;
			next_state.half_cnt = '0;
			next_state.div_cnt = '0;
			next_state.per_cnt = '0;
			next_state.seen_edge = 1'b0;
			next_state.band_valid = 1'b0;
			next_state.filter_stable_flag = 1'b0;
		end else begin
			// Ring oscillator model: toggle every half_len cycles
			if (state.half_cnt >= half_len - iclkg_pkg::HALF_W'(1)) begin
				next_state.half_cnt = '0;
				next_state.clk.fast_internal_clock = !state.clk.fast_internal_clock;
				fast_rise = !state.clk.fast_internal_clock;
			end else begin
				next_state.half_cnt = state.half_cnt + iclkg_pkg::HALF_W'(1);
			end

			// Modulo N divider, counted on fast clock rising edges
			if (bypass) begin
				next_state.div_cnt = '0;
				next_state.clk.base_clock = next_state.clk.fast_internal_clock;
			end else if (fast_rise) begin
				if (state.div_cnt >= multiplier_register - MULT_WIDTH'(1)) begin
					next_state.div_cnt = '0;
				end else begin
					next_state.div_cnt = state.div_cnt + MULT_WIDTH'(1);
				end
				next_state.clk.base_clock =
					(next_state.div_cnt < (multiplier_register >> 1));
			end
			base_rise = next_state.clk.base_clock && !state.clk.base_clock;

			// Downstream chain: osc output follows fast clock, then halves twice
			next_state.clk.osc_output_clock = next_state.clk.fast_internal_clock;
			if (next_state.clk.osc_output_clock && !state.clk.osc_output_clock) begin
				next_state.clk.gen_output_clock = !state.clk.gen_output_clock;
				gen_rise = !state.clk.gen_output_clock;
			end
			if (gen_rise) begin
				next_state.clk.bus_clock = !state.clk.bus_clock;
			end

			// Period counter saturates so a stalled base clock reads very slow
			if (state.per_cnt != '1) begin
				next_state.per_cnt = state.per_cnt + iclkg_pkg::PER_W'(1);
			end

			if (base_rise) begin
				// Restart at one: this edge is already the first cycle of the new period
				next_state.per_cnt = iclkg_pkg::PER_W'(1);
				next_state.seen_edge = 1'b1;
				// Longer period means lower frequency
				if (scaled(period, iclkg_pkg::PCT_85) > nom_scaled) begin
					band = iclkg_pkg::BAND_VSLOW;
				end else if (scaled(period, iclkg_pkg::PCT_95) > nom_scaled) begin
					band = iclkg_pkg::BAND_SLOW;
				end else if (period > iclkg_pkg::PER_W'(NOM_PERIOD)) begin
					band = iclkg_pkg::BAND_LSLOW;
				end else if (scaled(period, iclkg_pkg::PCT_105) > nom_scaled) begin
					band = iclkg_pkg::BAND_LFAST;
				end else if (scaled(period, iclkg_pkg::PCT_115) > nom_scaled) begin
					band = iclkg_pkg::BAND_FAST;
				end else begin
					band = iclkg_pkg::BAND_VFAST;
				end

				// First edge after enable has no full period behind it
				if (state.seen_edge) begin
					next_state.band = band;
					next_state.band_valid = 1'b1;
					next_state.filter_stable_flag =
						(scaled(period, iclkg_pkg::PCT_95) <= nom_scaled)
						&& (scaled(period, iclkg_pkg::PCT_105) >= nom_scaled);
					unique case (band)
						iclkg_pkg::BAND_VSLOW: begin
							step = iclkg_pkg::STEP_COARSE;
							step_up = 1'b0;
						end
						iclkg_pkg::BAND_SLOW: begin
							step = iclkg_pkg::STEP_MID;
							step_up = 1'b0;
						end
						iclkg_pkg::BAND_LSLOW: begin
							step = iclkg_pkg::STEP_FINE;
							step_up = 1'b0;
						end
						iclkg_pkg::BAND_LFAST: begin
							step = iclkg_pkg::STEP_FINE;
							step_up = 1'b1;
						end
						iclkg_pkg::BAND_FAST: begin
							step = iclkg_pkg::STEP_MID;
							step_up = 1'b1;
						end
						iclkg_pkg::BAND_VFAST: begin
							step = iclkg_pkg::STEP_COARSE;
							step_up = 1'b1;
						end
					endcase
					// Whole-word add: nibble moves only via stage carry or borrow
					if (step_up) begin
						next_state.word = state.word + step;
					end else begin
						next_state.word = state.word - step;
					end
				end
			end
		end
	end

	// State register
	always_ff @(posedge clock) begin
		if (!rstn) begin
			state <= '0;
			state.word <= WORD_INIT;
			state.band <= iclkg_pkg::BAND_LFAST;
		end else begin
			state <= next_state;
		end
	end

	// Outputs straight from state flops
	assign enables = state.en;
	assign clocks = state.clk;
	assign osc_divider_ctl = state.word[iclkg_pkg::WORD_W-1:iclkg_pkg::STAGE_W];
	assign osc_stage_ctl = state.word[iclkg_pkg::STAGE_W-1:0];
	assign error_band = state.band;
	assign error_band_valid = state.band_valid;
	assign filter_stable_flag = state.filter_stable_flag;

endmodule

// [bench/iclkg_core_chk.sv]
`timescale 1ns/1ns
// Port-level watcher for the generator core, system clock domain only
module iclkg_core_chk #(
	parameter int unsigned MULT_WIDTH = 7
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Controls
	input wire logic stop_mode,
	input wire logic int_osc_on_bit,
	input wire logic ext_path_on_bit,
	input wire logic [MULT_WIDTH-1:0] multiplier_register,
	input wire logic ext_clock_in,
	// Observed outputs
	input wire iclkg_pkg::iclkg_enables_type enables,
	input wire iclkg_pkg::iclkg_clocks_type clocks,
	input wire logic [3:0] osc_divider_ctl,
	input wire logic [7:0] osc_stage_ctl,
	input wire iclkg_pkg::iclkg_band_type error_band,
	input wire logic error_band_valid,
	input wire logic filter_stable_flag
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	// Enables and gating
	halt_on_stop_a: assert property (stop_mode |=> enables == 3'h4 && clocks == 6'h00)
		else $error("stop did not halt the clocks");
	int_enable_a: assert property (1'b1 |=>
		enables.int_osc_enable == ($past(int_osc_on_bit) && !$past(stop_mode)))
		else $error("internal enable wrong");
	int_off_low_a: assert property (!enables.int_osc_enable |->
		!clocks.fast_internal_clock && !clocks.base_clock) else $error("internal clocks not low");
	ext_follow_a: assert property (1'b1 |=> clocks.external_clock ==
		($past(ext_clock_in) && $past(ext_path_on_bit) && !$past(stop_mode)))
		else $error("external path wrong");
	ext_off_low_a: assert property (!enables.ext_path_enable |-> !clocks.external_clock)
		else $error("external clock not low");
	// Division chain: gen and bus move only on a rise of the one before; base follows fast in bypass
	bus_half_a: assert property ($changed(clocks.bus_clock) && enables.int_osc_enable |->
		$rose(clocks.gen_output_clock)) else $error("bus clock moved off a gen rise");
	gen_half_a: assert property ($changed(clocks.gen_output_clock)
		&& enables.int_osc_enable |-> $rose(clocks.osc_output_clock))
		else $error("gen clock moved off an osc rise");
	bypass_a: assert property ($stable(multiplier_register) && multiplier_register <= 1 |->
		clocks.base_clock == clocks.fast_internal_clock) else $error("bypass not taken");
	// Word moves by one band step, wrapping
	word_step_a: assert property ($changed({osc_divider_ctl, osc_stage_ctl}) |->
		({osc_divider_ctl, osc_stage_ctl} - $past({osc_divider_ctl, osc_stage_ctl}))
		inside {12'h001, 12'h008, 12'h020, 12'hfff, 12'hff8, 12'hfe0}) else $error("bad word step");
	// One correction per base period, taken on its rising edge
	step_on_base_a: assert property ($changed({osc_divider_ctl, osc_stage_ctl}) |->
		$rose(clocks.base_clock)) else $error("word moved off a base rise");
	stable_band_a: assert property (filter_stable_flag |-> error_band_valid)
		else $error("stable without a measurement");
endmodule

bind iclkg_core iclkg_core_chk #(.MULT_WIDTH(MULT_WIDTH)) chk (.clock(clock), .rstn(rstn),
	.stop_mode(stop_mode), .int_osc_on_bit(int_osc_on_bit), .ext_path_on_bit(ext_path_on_bit),
	.multiplier_register(multiplier_register), .ext_clock_in(ext_clock_in), .enables(enables),
	.clocks(clocks), .osc_divider_ctl(osc_divider_ctl), .osc_stage_ctl(osc_stage_ctl),
	.error_band(error_band), .error_band_valid(error_band_valid),
	.filter_stable_flag(filter_stable_flag));

// [bench/iclkg_siu.sv]
`timescale 1ns/1ns
// Downstream consumer counting rises of the osc output, gen output and bus clocks
module iclkg_siu (
	// Clock and count clear
	input wire logic clock,
	input wire logic clr,
	// Clocks from the generator
	input wire iclkg_pkg::iclkg_clocks_type clocks,
	// Rise counts
	output int osc_n,
	output int gen_n,
	output int bus_n
);
	iclkg_pkg::iclkg_clocks_type last;
	// Sampled on the system clock, as the real consumer would
	always @(posedge clock) begin
		last <= clocks;
		if (clr) begin
			osc_n <= 0;
			gen_n <= 0;
			bus_n <= 0;
		end else begin
			osc_n <= osc_n + int'(clocks.osc_output_clock && !last.osc_output_clock);
			gen_n <= gen_n + int'(clocks.gen_output_clock && !last.gen_output_clock);
			bus_n <= bus_n + int'(clocks.bus_clock && !last.bus_clock);
		end
	end
endmodule

// [bench/iclkg_core_test.sv]
`timescale 1ns/1ns
module iclkg_core_test;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic stop_mode = 1'b0;
	logic int_osc_on_bit = 1'b0;
	logic ext_path_on_bit = 1'b0;
	logic [6:0] multiplier_register = 7'h01;
	logic ext_clock_in = 1'b0;
	logic clr = 1'b1;
	iclkg_pkg::iclkg_enables_type enables;
	iclkg_pkg::iclkg_clocks_type clocks;
	logic [3:0] osc_divider_ctl;
	logic [7:0] osc_stage_ctl;
	iclkg_pkg::iclkg_band_type error_band;
	logic error_band_valid;
	logic filter_stable_flag;
	int osc_n;
	int gen_n;
	int bus_n;
	int err_total = 0;
	int comparisons = 0;
	int cycles = 0;
	// 100 MHz system clock
	always #5 clock = ~clock;
	// Short nominal period and a slow start word keep the loop quick
	iclkg_core #(.NOM_PERIOD(40), .WORD_INIT(12'h0c0)) dut (.clock(clock), .rstn(rstn),
		.stop_mode(stop_mode), .int_osc_on_bit(int_osc_on_bit), .ext_path_on_bit(ext_path_on_bit),
		.multiplier_register(multiplier_register), .ext_clock_in(ext_clock_in), .enables(enables),
		.clocks(clocks), .osc_divider_ctl(osc_divider_ctl), .osc_stage_ctl(osc_stage_ctl),
		.error_band(error_band), .error_band_valid(error_band_valid),
		.filter_stable_flag(filter_stable_flag));
	iclkg_siu sink (.clock(clock), .clr(clr), .clocks(clocks), .osc_n(osc_n), .gen_n(gen_n),
		.bus_n(bus_n));
	task check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task conclude;
		if (err_total == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Hang guard
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			err_total++;
			conclude();
		end
	end
	// Slow start: one coarse step down, then settling
	task t_loop;
		int k;
		@(posedge clock);
		int_osc_on_bit <= 1'b1;
		for (k = 0; k < 600 && error_band_valid !== 1'b1; k++) @(negedge clock);
		check(error_band, iclkg_pkg::BAND_VSLOW);
		for (k = 0; k < 50 && {osc_divider_ctl, osc_stage_ctl} === 12'h0c0; k++) @(negedge clock);
		check({osc_divider_ctl, osc_stage_ctl}, 12'h0a0);
		for (k = 0; k < 3000 && filter_stable_flag !== 1'b1; k++) @(negedge clock);
		check(filter_stable_flag, 1'b1);
	endtask
	// Fast rises per base period equal N
	task t_div;
		int n;
		logic pf;
		logic pb;
		@(posedge clock);
		multiplier_register <= 7'h04;
		repeat (600) @(posedge clock);
		repeat (2) begin
			n = 0;
			do begin
				pf = clocks.fast_internal_clock;
				pb = clocks.base_clock;
				@(negedge clock);
				if (clocks.fast_internal_clock && !pf)
					n++;
			end while (!(clocks.base_clock && !pb));
		end
		check(n, 4);
	endtask
	// N of zero and one pass the fast clock through
	task t_bypass;
		for (int v = 0; v < 2; v++) begin
			@(posedge clock);
			multiplier_register <= 7'(v);
			repeat (2) @(posedge clock);
			repeat (60) begin
				@(negedge clock);
				check(clocks.base_clock, clocks.fast_internal_clock);
			end
		end
	endtask
	// Bus at a quarter of osc and half of gen
	task t_bus;
		@(posedge clock);
		clr <= 1'b1;
		@(posedge clock);
		clr <= 1'b0;
		repeat (1500) @(posedge clock);
		@(negedge clock);
		check(gen_n > 3, 1'b1);
		check((gen_n - 2 * bus_n) inside {-1, 0, 1}, 1'b1);
		check((osc_n - 2 * gen_n) inside {-1, 0, 1}, 1'b1);
	endtask
	// External path follows the pin, then drops when turned off
	task t_ext;
		@(posedge clock);
		ext_path_on_bit <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			ext_clock_in <= i[0];
			@(posedge clock);
			@(negedge clock);
			check(clocks.external_clock, i[0]);
		end
		@(posedge clock);
		ext_clock_in <= 1'b1;
		ext_path_on_bit <= 1'b0;
		repeat (2) @(posedge clock);
		@(negedge clock);
		check(clocks.external_clock, 1'b0);
	endtask
	// Every combination of stop and the two on bits
	task t_enable;
		for (int i = 7; i >= 0; i--) begin
			@(posedge clock);
			{stop_mode, int_osc_on_bit, ext_path_on_bit} <= 3'(i);
			ext_clock_in <= 1'b1;
			repeat (2) @(posedge clock);
			@(negedge clock);
			check(enables, {i[2], i[1] & ~i[2], i[0] & ~i[2]});
			if (i[2])
				check(clocks, 6'h00);
			if (!i[1])
				check({clocks.fast_internal_clock, clocks.base_clock}, 2'h0);
		end
	endtask
	// Long base period walks the word below 000; nibble a to f must then act as nine
	task t_wrap;
		int k;
		int h;
		int exp_h;
		@(posedge clock);
		multiplier_register <= 7'h20;
		int_osc_on_bit <= 1'b1;
		for (k = 0; k < 20000 && osc_divider_ctl <= iclkg_pkg::DIV_SLOWEST; k++) @(negedge clock);
		check(osc_divider_ctl > iclkg_pkg::DIV_SLOWEST, 1'b1);
		// Word moved on a fast rise, so the high half that follows runs on the new word
		h = 0;
		while (h < 400 && clocks.fast_internal_clock === 1'b1) begin
			@(negedge clock);
			h++;
		end
		exp_h = iclkg_pkg::OSC_HALF_MIN
			+ ({iclkg_pkg::DIV_SLOWEST, osc_stage_ctl} >> iclkg_pkg::OSC_SHIFT);
		check(h, exp_h);
	endtask
	initial begin
		repeat (5) @(posedge clock);
		rstn <= 1'b1;
		t_loop();
		t_bus();
		t_div();
		t_bypass();
		t_ext();
		t_enable();
		t_wrap();
		conclude();
	end
endmodule
